// ===== plsc_params.svh
// Constants for the PLL serial control port: widths, reset values, pin slots
`ifndef PLSC_PARAMS_SVH
`define PLSC_PARAMS_SVH

// Control word layout widths
`define PLSC_PRESET_W 11
`define PLSC_CTRL_W 16
`define PLSC_CNT_W 5

// Control word after reset: readback driver enabled, all else off
`define PLSC_CTRL_RST 16'h0001

// Input synchroniser depth
`define PLSC_SYNC_STAGES 3

// Slots of the sampled pin vector
`define PLSC_PIN_N 13
`define PLSC_PIN_CS 0
`define PLSC_PIN_HOLD 1
`define PLSC_PIN_DIR 2
`define PLSC_PIN_SCK 3
`define PLSC_PIN_SDI 4
`define PLSC_PIN_PRESET_N 5
`define PLSC_PIN_OSC_P 6
`define PLSC_PIN_OSC_N 7
`define PLSC_PIN_OSC_S 8
`define PLSC_PIN_SYNC_P 9
`define PLSC_PIN_SYNC_N 10
`define PLSC_PIN_SYNC_S 11
`define PLSC_PIN_VCO_FB 12

`endif

// ===== plsc_pkg.sv
// Types shared by the PLL serial control port modules
package plsc_pkg;
  `include "plsc_params.svh"

  // Serial port mode, chosen by chip select and the direction line
  typedef enum logic [1:0] {PLSC_IDLE, PLSC_WRITE, PLSC_READ} plsc_mode_type;

  // Control word, first bit shifted in is the top of preset
  typedef struct packed {
    logic [`PLSC_PRESET_W-1:0] preset;
    logic sync_src_single;
    logic sync_pol_neg;
    logic test_src_single;
    logic test_route;
    logic readback_en;
  } plsc_ctrl_type;
endpackage

// ===== plsc_pin_if.sv
// Raw pins in, filtered levels and edges out, between top and synchroniser
`timescale 1ns/1ps
interface plsc_pin_if #(parameter int N = 1);
  logic [N-1:0] raw;
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport user (output raw, input lvl, input rise, input fall);
  modport filt (input raw, output lvl, output rise, output fall);
endinterface

// ===== plsc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module plsc_pin_sync #(
  parameter int N = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins and filtered results
  plsc_pin_if.filt pins
);
  import plsc_pkg::*;

  // Refuse an empty pin vector at elaboration
  if (N < 1)
  begin : g_bad_n
    $error("plsc_pin_sync: N must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      logic rise_r;
      logic fall_r;

      // Stage one feeds only stage two; metastability stays contained
      always_ff @(posedge clk)
      begin
        s1_r <= pins.raw[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end

      // A change counts once stages two and three agree
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          lvl_r <= 1'b0;
          rise_r <= 1'b0;
          fall_r <= 1'b0;
        end
        else
        begin
          rise_r <= (s2_r == s3_r) && s2_r && !lvl_r;
          fall_r <= (s2_r == s3_r) && !s2_r && lvl_r;
          if (s2_r == s3_r)
            lvl_r <= s2_r;
        end
      end

      assign pins.lvl[g] = lvl_r;
      assign pins.rise[g] = rise_r;
      assign pins.fall[g] = fall_r;
    end
  endgenerate
endmodule // plsc_pin_sync

// ===== plsc_top.sv
// PLL serial control port: three-line register access, hold, preset, sync, test routing
`timescale 1ns/1ps
`include "plsc_params.svh"
module plsc_top #(
  parameter int PRESET_W = `PLSC_PRESET_W
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Chip control pins
  input wire logic CS,
  input wire logic HOLD,
  input wire logic COUNTER_PRESET_N,
  // Serial control link
  input wire logic SERIAL_DIRECTION_SEL,
  input wire logic SERIAL_SHIFT_CLK,
  input wire logic SERIAL_IN_LINE,
  output logic SERIAL_READBACK_OUT,
  output logic SERIAL_READBACK_OE_N,
  // Oscillator inputs
  input wire logic EXT_OSC_DIFF_POS_IN,
  input wire logic EXT_OSC_DIFF_NEG_IN,
  input wire logic EXT_OSC_SINGLE_IN,
  input wire logic VCO_FEEDBACK_IN,
  // Sync inputs
  input wire logic LINE_SYNC_DIFF_POS_IN,
  input wire logic LINE_SYNC_DIFF_NEG_IN,
  input wire logic LINE_SYNC_SINGLE_IN,
  // Loop and counter results
  output logic PHASE_DET_EN,
  output logic LINE_SYNC_ACTIVE,
  output logic [PRESET_W-1:0] COUNTER_VALUE,
  output logic COUNTER_TERMINAL,
  output logic POWER_SAVE
);
  import plsc_pkg::*;

  // Counter width must match the preset field; refused at elaboration
  if (PRESET_W != `PLSC_PRESET_W)
  begin : g_bad_preset_w
    $error("plsc_top: PRESET_W must equal the preset field width");
  end

  plsc_pin_if #(.N(`PLSC_PIN_N)) pin_bus ();

  // Pin vector gathered for the synchroniser
  assign pin_bus.raw[`PLSC_PIN_CS] = CS;
  assign pin_bus.raw[`PLSC_PIN_HOLD] = HOLD;
  assign pin_bus.raw[`PLSC_PIN_DIR] = SERIAL_DIRECTION_SEL;
  assign pin_bus.raw[`PLSC_PIN_SCK] = SERIAL_SHIFT_CLK;
  assign pin_bus.raw[`PLSC_PIN_SDI] = SERIAL_IN_LINE;
  assign pin_bus.raw[`PLSC_PIN_PRESET_N] = COUNTER_PRESET_N;
  assign pin_bus.raw[`PLSC_PIN_OSC_P] = EXT_OSC_DIFF_POS_IN;
  assign pin_bus.raw[`PLSC_PIN_OSC_N] = EXT_OSC_DIFF_NEG_IN;
  assign pin_bus.raw[`PLSC_PIN_OSC_S] = EXT_OSC_SINGLE_IN;
  assign pin_bus.raw[`PLSC_PIN_SYNC_P] = LINE_SYNC_DIFF_POS_IN;
  assign pin_bus.raw[`PLSC_PIN_SYNC_N] = LINE_SYNC_DIFF_NEG_IN;
  assign pin_bus.raw[`PLSC_PIN_SYNC_S] = LINE_SYNC_SINGLE_IN;
  assign pin_bus.raw[`PLSC_PIN_VCO_FB] = VCO_FEEDBACK_IN;

  plsc_pin_sync #(.N(`PLSC_PIN_N)) u_sync (
    .clk (MCLK),
    .srst (SRST),
    .pins (pin_bus.filt)
  );

  // Filtered pin views
  logic cs_on;
  logic hold_on;
  logic dir_read;
  logic sck_rise;
  logic sck_fall;
  logic sdi;
  logic preset_req;
  assign cs_on = pin_bus.lvl[`PLSC_PIN_CS];
  assign hold_on = pin_bus.lvl[`PLSC_PIN_HOLD];
  assign dir_read = pin_bus.lvl[`PLSC_PIN_DIR];
  assign sck_rise = pin_bus.rise[`PLSC_PIN_SCK];
  assign sck_fall = pin_bus.fall[`PLSC_PIN_SCK];
  assign sdi = pin_bus.lvl[`PLSC_PIN_SDI];
  assign preset_req = !pin_bus.lvl[`PLSC_PIN_PRESET_N];

  plsc_mode_type mode_r;
  plsc_mode_type mode_nxt;
  plsc_ctrl_type ctrl_r;
  logic [`PLSC_CTRL_W-1:0] wr_shift_r;
  logic [`PLSC_CNT_W-1:0] wr_cnt_r;
  logic [`PLSC_CTRL_W-1:0] rd_shift_r;
  logic [PRESET_W-1:0] cnt_r;
  logic wr_full;
  logic commit;
  logic enter_read;
  plsc_ctrl_type wr_word;
  logic rb_en_now;

  // Mode from chip select and direction line
  always_comb
  begin
    if (!cs_on)
      mode_nxt = PLSC_IDLE;
    else if (dir_read)
      mode_nxt = PLSC_READ;
    else
      mode_nxt = PLSC_WRITE;
  end

  // A write only takes effect with a full word; short frames are dropped
  assign wr_full = (wr_cnt_r == 5'(`PLSC_CTRL_W));
  assign commit = (mode_r == PLSC_WRITE) && (mode_nxt != PLSC_WRITE) && wr_full;
  assign enter_read = (mode_r != PLSC_READ) && (mode_nxt == PLSC_READ);
  // Driver follows a word in its commit cycle, so a disabling write never glitches it on
  assign wr_word = plsc_ctrl_type'(wr_shift_r);
  assign rb_en_now = commit ? wr_word.readback_en : ctrl_r.readback_en;

  // Mode register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      mode_r <= PLSC_IDLE;
    else
      mode_r <= mode_nxt;
  end

  // Write shifter and bit count; only the count is cleared between frames
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      wr_shift_r <= '0;
      wr_cnt_r <= '0;
    end
    else
    begin
      case (mode_r)
        PLSC_WRITE:
        begin
          if (sck_rise && mode_nxt == PLSC_WRITE)
          begin
            wr_shift_r <= {wr_shift_r[`PLSC_CTRL_W-2:0], sdi};
            if (!wr_full)
              wr_cnt_r <= wr_cnt_r + 5'(1);
          end
        end
        default:
          wr_cnt_r <= '0;
      endcase
    end
  end

  // Control register, kept through power saving
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      ctrl_r <= plsc_ctrl_type'(`PLSC_CTRL_RST);
    else if (commit)
      ctrl_r <= wr_word;
  end

  // Read snapshot and readback bit, top bit first
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      rd_shift_r <= '0;
      SERIAL_READBACK_OUT <= 1'b0;
    end
    else if (enter_read)
      rd_shift_r <= commit ? wr_shift_r : ctrl_r;
    else if (mode_r == PLSC_READ && sck_fall)
    begin
      SERIAL_READBACK_OUT <= rd_shift_r[`PLSC_CTRL_W-1];
      rd_shift_r <= {rd_shift_r[`PLSC_CTRL_W-2:0], 1'b0};
    end
  end

  // Readback driver: on only when reading, enabled and selected
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      SERIAL_READBACK_OE_N <= 1'b1;
    else
      SERIAL_READBACK_OE_N <= !(rb_en_now && mode_nxt == PLSC_READ);
  end

  // Phase detector stops on hold or power saving
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      PHASE_DET_EN <= 1'b0;
      POWER_SAVE <= 1'b1;
    end
    else
    begin
      PHASE_DET_EN <= cs_on && !hold_on;
      POWER_SAVE <= !cs_on;
    end
  end

  // Sync source and polarity; a negative sync is inverted to active high
  logic sync_diff;
  logic sync_sel;
  assign sync_diff = pin_bus.lvl[`PLSC_PIN_SYNC_P] && !pin_bus.lvl[`PLSC_PIN_SYNC_N];
  assign sync_sel = ctrl_r.sync_src_single ? pin_bus.lvl[`PLSC_PIN_SYNC_S] : sync_diff;
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      LINE_SYNC_ACTIVE <= 1'b0;
    else
      LINE_SYNC_ACTIVE <= cs_on && (sync_sel ^ ctrl_r.sync_pol_neg);
  end

  // Counter clock: the loop feedback, or an external oscillator in test
  logic osc_diff_prev_r;
  logic osc_diff;
  logic osc_diff_rise;
  logic cnt_tick;
  assign osc_diff = pin_bus.lvl[`PLSC_PIN_OSC_P] && !pin_bus.lvl[`PLSC_PIN_OSC_N];
  assign osc_diff_rise = osc_diff && !osc_diff_prev_r;
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      osc_diff_prev_r <= 1'b0;
    else
      osc_diff_prev_r <= osc_diff;
  end
  always_comb
  begin
    if (!ctrl_r.test_route)
      cnt_tick = pin_bus.rise[`PLSC_PIN_VCO_FB];
    else if (ctrl_r.test_src_single)
      cnt_tick = pin_bus.rise[`PLSC_PIN_OSC_S];
    else
      cnt_tick = osc_diff_rise;
  end

  // Programmable down counter; preset wins over counting
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      cnt_r <= '0;
      COUNTER_TERMINAL <= 1'b0;
    end
    else
    begin
      COUNTER_TERMINAL <= 1'b0;
      if (!cs_on)
        cnt_r <= cnt_r;
      else if (preset_req)
        cnt_r <= ctrl_r.preset;
      else if (cnt_tick)
      begin
        if (cnt_r == '0)
        begin
          cnt_r <= ctrl_r.preset;
          COUNTER_TERMINAL <= 1'b1;
        end
        else
          cnt_r <= cnt_r - PRESET_W'(1);
      end
    end
  end

  // Counter value out of its own flop
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      COUNTER_VALUE <= '0;
    else
      COUNTER_VALUE <= cnt_r;
  end
endmodule // plsc_top

// ===== plsc_top_properties.sv
// Concurrent checks on the PLL serial control port pins
`timescale 1ns/1ps
module plsc_top_properties #(
  parameter int PRESET_W = 11
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Pins
  input wire logic CS,
  input wire logic HOLD,
  input wire logic COUNTER_PRESET_N,
  input wire logic SERIAL_DIRECTION_SEL,
  input wire logic SERIAL_SHIFT_CLK,
  // Results
  input wire logic SERIAL_READBACK_OUT,
  input wire logic SERIAL_READBACK_OE_N,
  input wire logic PHASE_DET_EN,
  input wire logic [PRESET_W-1:0] COUNTER_VALUE,
  input wire logic COUNTER_TERMINAL,
  input wire logic POWER_SAVE
);
  logic [3:0] fall_age_r;
  logic [3:0] preset_age_r;
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  // Age of the last shift clock fall, saturating so it never wraps
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      fall_age_r <= 4'hF;
    else if ($fell(SERIAL_SHIFT_CLK))
      fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hF)
      fall_age_r <= fall_age_r + 4'h1;
  end
  // Length of the current preset pulse
  always_ff @(posedge MCLK)
  begin
    if (SRST || COUNTER_PRESET_N)
      preset_age_r <= 4'h0;
    else if (preset_age_r != 4'hF)
      preset_age_r <= preset_age_r + 4'h1;
  end
  // Synchroniser delay bounds every reaction below but the last two, which check the counter outputs alone
  save_enter_a: assert property ($fell(CS) |-> ##[2:8] POWER_SAVE)
    else $error("power save not entered");
  save_leave_a: assert property ($rose(CS) |-> ##[2:8] !POWER_SAVE)
    else $error("power save not left");
  hold_stop_a: assert property ($rose(HOLD) |-> ##[2:8] !PHASE_DET_EN)
    else $error("phase detector kept running");
  oe_write_off_a: assert property ($fell(SERIAL_DIRECTION_SEL) |-> ##[2:8] SERIAL_READBACK_OE_N)
    else $error("readback driver on in write");
  readback_edge_a: assert property ($changed(SERIAL_READBACK_OUT) && SERIAL_DIRECTION_SEL
    && $past(SERIAL_DIRECTION_SEL, 8) |-> fall_age_r inside {[4'h2:4'h8]})
    else $error("readback moved without a falling shift edge");
  preset_hold_a: assert property (preset_age_r > 4'h7
    |-> $stable(COUNTER_VALUE) && !COUNTER_TERMINAL)
    else $error("counter moved during preset");
  frozen_count_a: assert property (POWER_SAVE && $past(POWER_SAVE) && $past(POWER_SAVE, 2)
    |-> $stable(COUNTER_VALUE))
    else $error("counter moved in power save");
  wrap_pulse_a: assert property (COUNTER_TERMINAL |=> !COUNTER_TERMINAL)
    else $error("terminal pulse too long");
endmodule // plsc_top_properties

bind plsc_top plsc_top_properties #(.PRESET_W(PRESET_W)) plsc_top_properties_i (.MCLK(MCLK),
  .SRST(SRST), .CS(CS), .HOLD(HOLD), .COUNTER_PRESET_N(COUNTER_PRESET_N),
  .SERIAL_DIRECTION_SEL(SERIAL_DIRECTION_SEL), .SERIAL_SHIFT_CLK(SERIAL_SHIFT_CLK),
  .SERIAL_READBACK_OUT(SERIAL_READBACK_OUT), .SERIAL_READBACK_OE_N(SERIAL_READBACK_OE_N),
  .PHASE_DET_EN(PHASE_DET_EN), .COUNTER_VALUE(COUNTER_VALUE),
  .COUNTER_TERMINAL(COUNTER_TERMINAL), .POWER_SAVE(POWER_SAVE));

// ===== plsc_host_model.sv
// Host model driving the three-line serial control link
`timescale 1ns/1ps
module plsc_host_model (
  // Bench clock for frame alignment
  input wire logic clk,
  // Serial control link
  output logic sck,
  output logic dir,
  output logic sdi,
  input wire logic rb
);
  // Shift clock stands low outside frames
  initial
  begin
    sck = 1'b0;
    dir = 1'b0;
    sdi = 1'b0;
  end
  // Sixteen 64 ns shift clocks, MSB first; read bits taken at the next rise
  task automatic shift_bits(input logic rd_mode, input logic [15:0] wd, output logic [15:0] rd);
    for (int i = 15; i >= 0; i--)
    begin
      sdi = rd_mode ? ~sdi : wd[i];
      #32;
      if (i < 15)
        rd[i + 1] = rb;
      sck = 1'b1;
      #32;
      sck = 1'b0;
    end
    #32;
    rd[0] = rb;
  endtask
  // Direction low then high; the rise commits a write or snapshots for a read
  task automatic frame(input logic rd_mode, input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk);
    dir = 1'b0;
    #64;
    if (!rd_mode)
      shift_bits(1'b0, wd, rd);
    #64;
    dir = 1'b1;
    #64;
    if (rd_mode)
      shift_bits(1'b1, wd, rd);
    // Hand back on a falling bench clock edge, where the bench drives
    @(negedge clk);
  endtask
endmodule // plsc_host_model

// ===== test_pll_serial_control_port.sv
// Self-checking bench for the PLL serial control port
`timescale 1ns/1ps
module test_pll_serial_control_port;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cs = 1'b0;
  logic hold = 1'b0;
  logic preset_n = 1'b1;
  logic osc_p = 1'b0;
  logic osc_s = 1'b0;
  logic ext_osc_single_in = 1'b0;
  logic sync_p = 1'b1;
  logic sync_s = 1'b0;
  logic [15:0] term_seen = 16'h0000;
  logic sck, dir, sdi, rb, rb_oe_n, pd_en, sync_act, term, psave;
  logic [10:0] cnt;
  logic [15:0] rd;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // Device and host; unused sync and oscillator halves held at rest
  plsc_top plsc_top_i (.MCLK(mclk), .SRST(srst), .CS(cs), .HOLD(hold),
    .COUNTER_PRESET_N(preset_n), .SERIAL_DIRECTION_SEL(dir), .SERIAL_SHIFT_CLK(sck),
    .SERIAL_IN_LINE(sdi), .SERIAL_READBACK_OUT(rb), .SERIAL_READBACK_OE_N(rb_oe_n),
    .EXT_OSC_DIFF_POS_IN(osc_p), .EXT_OSC_DIFF_NEG_IN(1'b0), .EXT_OSC_SINGLE_IN(osc_s),
    .VCO_FEEDBACK_IN(ext_osc_single_in), .LINE_SYNC_DIFF_POS_IN(sync_p), .LINE_SYNC_DIFF_NEG_IN(1'b0),
    .LINE_SYNC_SINGLE_IN(sync_s), .PHASE_DET_EN(pd_en), .LINE_SYNC_ACTIVE(sync_act),
    .COUNTER_VALUE(cnt), .COUNTER_TERMINAL(term), .POWER_SAVE(psave));
  plsc_host_model plsc_host_model_i (.clk(mclk), .sck(sck), .dir(dir), .sdi(sdi), .rb(rb));
  // Terminal pulses counted mid-cycle, where the flop output has settled
  always @(negedge mclk)
  begin
    if (term === 1'b1)
      term_seen <= term_seen + 16'h0001;
  end
  // Shared helpers
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk_bit(string what, logic exp, logic seen);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic chk_word(string what, logic [15:0] exp, logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(ref logic s);
    s = 1'b1;
    cyc(8);
    s = 1'b0;
    cyc(8);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Scenarios
  task automatic t_wake();
    chk_bit("power save", 1'b1, psave);
    chk_bit("readback oe_n", 1'b1, rb_oe_n);
    cs = 1'b1;
    cyc(10);
    chk_bit("power save", 1'b0, psave);
    chk_bit("phase detect", 1'b1, pd_en);
    $display("test wake done");
  endtask
  task automatic t_rw();
    plsc_host_model_i.frame(1'b0, 16'hB461, rd);
    chk_bit("readback oe_n", 1'b0, rb_oe_n);
    plsc_host_model_i.frame(1'b1, 16'h0000, rd);
    chk_word("readback", 16'hB461, rd);
    plsc_host_model_i.frame(1'b0, 16'hB460, rd);
    chk_bit("readback oe_n", 1'b1, rb_oe_n);
    plsc_host_model_i.frame(1'b0, 16'h8421, rd);
    plsc_host_model_i.frame(1'b1, 16'h0000, rd);
    chk_word("readback", 16'h8421, rd);
    $display("test write read done");
  endtask
  task automatic t_hold();
    hold = 1'b1;
    cyc(10);
    chk_bit("phase detect", 1'b0, pd_en);
    hold = 1'b0;
    cyc(10);
    chk_bit("phase detect", 1'b1, pd_en);
    $display("test hold done");
  endtask
  // Source, polarity and input level; single input always opposite to diff
  task automatic t_sync();
    for (int k = 0; k < 8; k++)
    begin
      if (k[0] == 1'b0)
        plsc_host_model_i.frame(1'b0, {11'h000, k[2:1], 3'b001}, rd);
      sync_p = k[0];
      sync_s = ~k[0];
      cyc(10);
      chk_bit("sync active", (k[2] ? ~k[0] : k[0]) ^ k[1], sync_act);
    end
    $display("test sync done");
  endtask
  task automatic t_count();
    plsc_host_model_i.frame(1'b0, 16'h0067, rd);
    preset_n = 1'b0;
    tick(osc_s);
    preset_n = 1'b1;
    cyc(8);
    chk_word("counter", 16'h0003, {5'h00, cnt});
    tick(ext_osc_single_in);
    chk_word("counter", 16'h0003, {5'h00, cnt});
    tick(osc_s);
    chk_word("counter", 16'h0002, {5'h00, cnt});
    plsc_host_model_i.frame(1'b0, 16'h0063, rd);
    tick(osc_s);
    tick(osc_p);
    chk_word("counter", 16'h0001, {5'h00, cnt});
    tick(osc_p);
    tick(osc_p);
    chk_word("counter", 16'h0003, {5'h00, cnt});
    chk_word("terminal pulses", 16'h0001, term_seen);
    plsc_host_model_i.frame(1'b0, 16'h0061, rd);
    tick(ext_osc_single_in);
    chk_word("counter", 16'h0002, {5'h00, cnt});
    $display("test counter done");
  endtask
  task automatic t_power();
    cs = 1'b0;
    cyc(10);
    chk_bit("power save", 1'b1, psave);
    chk_bit("readback oe_n", 1'b1, rb_oe_n);
    chk_bit("sync active", 1'b0, sync_act);
    tick(ext_osc_single_in);
    chk_word("counter", 16'h0002, {5'h00, cnt});
    plsc_host_model_i.frame(1'b0, 16'hFFFF, rd);
    cs = 1'b1;
    cyc(10);
    plsc_host_model_i.frame(1'b1, 16'h0000, rd);
    chk_word("readback", 16'h0061, rd);
    $display("test power save done");
  endtask
  // Ceiling well above the roughly 4000 cycles the tests take
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Main sequence
  initial
  begin
    cyc(6);
    srst = 1'b0;
    cyc(2);
    t_wake();
    t_rw();
    t_hold();
    t_sync();
    t_count();
    t_power();
    conclude();
  end
endmodule // test_pll_serial_control_port
